// >>> inc/crf_pkg.sv
package crf_pkg;
  localparam int CRF_NREG = 32;
  localparam int CRF_AV_AW = 7;
  localparam logic [4:0] CRF_PTR_BASE = 5'h1a;
  localparam logic [4:0] CRF_PTR_Z = 5'h1e;
  localparam int CRF_SB_I = 7;
  localparam int CRF_SB_T = 6;
  localparam int CRF_SB_H = 5;
  localparam int CRF_SB_S = 4;
  localparam int CRF_SB_V = 3;
  localparam int CRF_SB_N = 2;
  localparam int CRF_SB_Z = 1;
  localparam int CRF_SB_C = 0;
  localparam logic [7:0] CRF_FLAG_MASK = 8'h2f;
  localparam logic [7:0] CRF_STATUS_RST = 8'h00;
  localparam logic [7:0] CRF_REG_RST = 8'h00;
  localparam logic [15:0] CRF_IO_BASE = 16'h0020;
  localparam logic [15:0] CRF_IO_LAST = 16'h005f;
  localparam logic [15:0] CRF_STATUS_ADDR = 16'h005f;
  localparam logic [CRF_AV_AW-1:0] CRF_AV_STATUS = 7'h5f;

  typedef enum logic [1:0] {
    CRF_S8_8, CRF_S88_8, CRF_S88_16, CRF_S16_16
  } crf_scheme_t;

  typedef enum logic [1:0] {
    CRF_PM_DISP, CRF_PM_POSTINC, CRF_PM_PREDEC, CRF_PM_NONE
  } crf_pmode_t;

  typedef struct packed {
    logic        valid;
    crf_scheme_t scheme;
    logic [4:0]  src_a;
    logic [4:0]  src_b;
  } crf_op_t;

  typedef struct packed {
    logic        valid;
    crf_scheme_t scheme;
    logic [4:0]  dst;
    logic [15:0] data;
  } crf_res_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] mask;
    logic [7:0] value;
  } crf_flag_t;

  typedef struct packed {
    logic       valid;
    logic [4:0] reg_idx;
    logic [2:0] bit_idx;
  } crf_bit_t;

  typedef struct packed {
    logic       valid;
    logic [1:0] sel;
    crf_pmode_t mode;
    logic [5:0] disp;
  } crf_ptr_t;

  typedef struct packed {
    logic        valid;
    logic        we;
    logic        is_io;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } crf_ds_t;

  typedef struct packed {
    logic        valid;
    logic        we;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } crf_mem_t;

  typedef struct packed {
    logic sei;
    logic cli;
    logic return_from_irq_instr;
    logic call;
  } crf_ictl_t;
endpackage

// >>> verilog/crf_regfile_status.sv
module crf_regfile_status
  import crf_pkg::*;
#(
  parameter int NIRQ = 8
) (
  input  wire logic                 clk,           // cpu clock
  input  wire logic                 rstn,          // async reset
  input  wire crf_op_t              op_i,          // operand read request
  output logic [15:0]               opnd_a,        // operand a
  output logic [15:0]               opnd_b,        // operand b
  output logic                      opnd_valid,    // operands stand
  input  wire crf_res_t             res_i,         // alu result write
  input  wire crf_flag_t            flag_i,        // alu flag update
  input  wire crf_bit_t             bst_i,         // bit store to t
  input  wire crf_bit_t             bld_i,         // bit load from t
  input  wire crf_ptr_t             ptr_i,         // pointer access
  output logic [15:0]               ptr_addr,      // effective address
  output logic                      ptr_valid,     // address stands
  output logic [15:0]               lpm_addr,      // flash table pointer
  input  wire crf_ds_t              ds_i,          // load/store/io access
  output logic [7:0]                ds_rdata,      // local read data
  output logic                      ds_rvalid,     // local read done
  output crf_mem_t                  mem_o,         // forwarded access
  input  wire logic [15:0]          fetch_word,    // fetched word
  input  wire logic                 fetch_valid,   // word present
  input  wire logic                 fetch_long,    // first of two words
  output logic [15:0]               exec_word,     // executing word
  output logic [15:0]               exec_ext,      // second word
  output logic                      exec_valid,    // instruction ready
  output logic                      exec_long,     // two-word form
  input  wire crf_ictl_t            ictl_i,        // sei cli return_from_irq_instr call
  input  wire logic [NIRQ-1:0]      irq_req,       // enabled sources
  input  wire logic [15:0]          cur_pc,        // return address
  output logic                      irq_take,      // interrupt taken
  output logic [$clog2(NIRQ)-1:0]   irq_vec,       // taken vector
  output logic                      push_valid,    // push request
  output logic [15:0]               push_pc,       // pushed address
  output logic [7:0]                cpu_status_flags, // status
  input  wire logic [CRF_AV_AW-1:0] av_address,    // word index
  input  wire logic                 av_read,       // read
  input  wire logic                 av_write,      // write
  input  wire logic [31:0]          av_writedata,  // write data
  input  wire logic [3:0]           av_byteenable, // lanes
  output logic [31:0]               av_readdata,   // read data
  output logic                      av_waitrequest // wait
);
  localparam int IW = $clog2(NIRQ);

  if (NIRQ < 2 || NIRQ > 64) begin : g_chk
    $error("NIRQ must lie in 2..64");
  end

  typedef enum logic {PF_FIRST, PF_SECOND} crf_pf_t;

  logic [7:0]  regs [CRF_NREG];
  logic [7:0]  next_reg [CRF_NREG];
  logic [7:0]  status;
  logic [7:0]  next_status;
  logic        hold;
  logic        av_ack;
  crf_pf_t     pf_state;

  // bus decode; ack stands while wait is low
  assign av_ack   = ~av_waitrequest;
  wire av_req     = (av_read | av_write) & ~av_ack;
  wire av_reg_hit = (av_address[6:5] == 2'b00);
  wire av_st_hit  = (av_address == CRF_AV_STATUS);
  wire av_wr_now  = av_write & av_ack & av_byteenable[0];
  wire av_reg_wr  = av_wr_now & av_reg_hit;
  wire av_st_wr   = av_wr_now & av_st_hit;
  wire [7:0] av_rd_byte = av_reg_hit ? regs[av_address[4:0]] :
                          av_st_hit  ? status : 8'h00;

  // data space decode
  wire [15:0] ds_addr   = ds_i.is_io ? (CRF_IO_BASE + {10'h000, ds_i.addr[5:0]})
                                     : ds_i.addr;
  wire        ds_reg    = ds_i.valid & (ds_addr < CRF_IO_BASE);
  wire        ds_st     = ds_i.valid & (ds_addr == CRF_STATUS_ADDR);
  wire        ds_fwd    = ds_i.valid & ~ds_reg & ~ds_st;
  wire        ds_reg_wr = ds_reg & ds_i.we;
  wire        ds_st_wr  = ds_st & ds_i.we;
  wire        ds_io_rng = ds_addr <= CRF_IO_LAST;

  // pointer pair selection and update value
  wire [4:0]  ptr_lo_idx = CRF_PTR_BASE + {2'b00, ptr_i.sel, 1'b0};
  wire [4:0]  ptr_hi_idx = ptr_lo_idx | 5'h01;
  wire        ptr_ok     = ptr_i.valid & (ptr_i.sel != 2'b11);
  wire [15:0] ptr_cur    = {regs[ptr_hi_idx], regs[ptr_lo_idx]};
  wire [15:0] ptr_inc    = ptr_cur + 16'h0001;
  wire [15:0] ptr_dec    = ptr_cur - 16'h0001;
  wire        ptr_upd    = ptr_ok & ((ptr_i.mode == CRF_PM_POSTINC) |
                                     (ptr_i.mode == CRF_PM_PREDEC));
  wire [15:0] ptr_new    = (ptr_i.mode == CRF_PM_PREDEC) ? ptr_dec : ptr_inc;
  wire [15:0] ptr_eff    = (ptr_i.mode == CRF_PM_DISP)   ?
                           ptr_cur + {10'h000, ptr_i.disp} :
                           (ptr_i.mode == CRF_PM_PREDEC) ? ptr_dec : ptr_cur;

  // result width and bit load value
  wire        res_wide = (res_i.scheme == CRF_S88_16) |
                         (res_i.scheme == CRF_S16_16);
  wire [4:0]  res_hi   = res_i.dst + 5'h01;
  logic [7:0] bld_val;

  always_comb begin
    bld_val = regs[bld_i.reg_idx];
    bld_val[bld_i.bit_idx] = status[CRF_SB_T];
  end

  // next value of every working register
  for (genvar i = 0; i < CRF_NREG; i++) begin : g_reg
    wire lo_hit  = res_i.valid & (res_i.dst == 5'(i));
    wire hi_hit  = res_i.valid & res_wide & (res_hi == 5'(i));
    wire bld_hit = bld_i.valid & (bld_i.reg_idx == 5'(i));
    wire pl_hit  = ptr_upd & (ptr_lo_idx == 5'(i));
    wire ph_hit  = ptr_upd & (ptr_hi_idx == 5'(i));
    wire ds_hit  = ds_reg_wr & (ds_addr[4:0] == 5'(i));
    wire av_hit  = av_reg_wr & (av_address[4:0] == 5'(i));
    assign next_reg[i] = lo_hit  ? res_i.data[7:0]  :
                         hi_hit  ? res_i.data[15:8] :
                         bld_hit ? bld_val          :
                         pl_hit  ? ptr_new[7:0]     :
                         ph_hit  ? ptr_new[15:8]    :
                         ds_hit  ? ds_i.wdata       :
                         av_hit  ? av_writedata[7:0] : regs[i];
  end

  // register array, one cycle per write
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int k = 0; k < CRF_NREG; k++) begin
        regs[k] <= CRF_REG_RST;
      end
    end else begin
      regs <= next_reg;
    end
  end

  // operand selection with write-through of this cycle's result
  wire op_wide_a = (op_i.scheme == CRF_S16_16);
  wire [4:0] op_a_hi = op_i.src_a + 5'h01;
  wire [15:0] next_opnd_a = op_wide_a ?
                            {next_reg[op_a_hi], next_reg[op_i.src_a]} :
                            {8'h00, next_reg[op_i.src_a]};
  wire op_two = (op_i.scheme == CRF_S88_8) | (op_i.scheme == CRF_S88_16);
  wire [15:0] next_opnd_b = op_two ? {8'h00, next_reg[op_i.src_b]} : 16'h0000;

  // operand registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      opnd_a     <= 16'h0000;
      opnd_b     <= 16'h0000;
      opnd_valid <= 1'b0;
    end else begin
      opnd_a     <= next_opnd_a;
      opnd_b     <= next_opnd_b;
      opnd_valid <= op_i.valid;
    end
  end

  // interrupt choice, lowest index wins
  logic [IW-1:0] irq_pick;

  always_comb begin
    irq_pick = '0;
    for (int k = NIRQ - 1; k >= 0; k--) begin
      if (irq_req[k]) begin
        irq_pick = IW'(k);
      end
    end
  end

  wire irq_grant = status[CRF_SB_I] & ~hold & ~ictl_i.cli & (|irq_req);

  // status next value; hardware events apply over software writes
  always_comb begin
    next_status = status;
    if (av_st_wr) begin
      next_status = av_writedata[7:0];
    end
    if (ds_st_wr) begin
      next_status = ds_i.wdata;
    end
    if (flag_i.valid) begin
      next_status = (next_status & ~(flag_i.mask & CRF_FLAG_MASK)) |
                    (flag_i.value & flag_i.mask & CRF_FLAG_MASK);
    end
    if (bst_i.valid) begin
      next_status[CRF_SB_T] = regs[bst_i.reg_idx][bst_i.bit_idx];
    end
    if (ictl_i.sei | ictl_i.return_from_irq_instr) begin
      next_status[CRF_SB_I] = 1'b1;
    end
    if (ictl_i.cli | irq_grant) begin
      next_status[CRF_SB_I] = 1'b0;
    end
    next_status[CRF_SB_S] = next_status[CRF_SB_N] ^ next_status[CRF_SB_V];
  end

  // status register; H V N Z C held as bits 5,3,2,1,0
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      status <= CRF_STATUS_RST;
    end else begin
      status <= next_status;
    end
  end

  assign cpu_status_flags = status;

  // interrupt entry and return address push
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hold       <= 1'b0;
      irq_take   <= 1'b0;
      irq_vec    <= '0;
      push_valid <= 1'b0;
      push_pc    <= 16'h0000;
    end else begin
      hold       <= ictl_i.sei | ictl_i.return_from_irq_instr;
      irq_take   <= irq_grant;
      irq_vec    <= irq_pick;
      push_valid <= irq_grant | ictl_i.call;
      push_pc    <= cur_pc;
    end
  end

  // pointer effective address
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ptr_addr  <= 16'h0000;
      ptr_valid <= 1'b0;
    end else begin
      ptr_addr  <= ptr_eff;
      ptr_valid <= ptr_ok;
    end
  end

  assign lpm_addr = {regs[CRF_PTR_Z | 5'h01], regs[CRF_PTR_Z]};

  // local data-space reads and forwarding of i/o and extended space
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ds_rdata  <= 8'h00;
      ds_rvalid <= 1'b0;
      mem_o     <= '0;
    end else begin
      ds_rdata  <= ds_st ? status : regs[ds_addr[4:0]];
      ds_rvalid <= (ds_reg | ds_st) & ~ds_i.we;
      mem_o.valid <= ds_fwd & (ds_io_rng | ~ds_i.is_io);
      mem_o.we    <= ds_i.we;
      mem_o.addr  <= ds_addr;
      mem_o.wdata <= ds_i.wdata;
    end
  end

  // prefetch stage: one word executes while the next is captured
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pf_state   <= PF_FIRST;
      exec_word  <= 16'h0000;
      exec_ext   <= 16'h0000;
      exec_valid <= 1'b0;
      exec_long  <= 1'b0;
    end else begin
      exec_valid <= 1'b0;
      if (fetch_valid) begin
        unique case (pf_state)
          PF_FIRST: begin
            exec_word  <= fetch_word;
            exec_long  <= fetch_long;
            exec_valid <= ~fetch_long;
            pf_state   <= fetch_long ? PF_SECOND : PF_FIRST;
          end
          PF_SECOND: begin
            exec_ext   <= fetch_word;
            exec_valid <= 1'b1;
            pf_state   <= PF_FIRST;
          end
        endcase
      end
    end
  end

  // avalon slave: one wait cycle, then answer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      av_waitrequest <= 1'b1;
      av_readdata    <= 32'h0000_0000;
    end else begin
      av_waitrequest <= ~av_req; // one wait state, then answer
      if (av_req) begin
        av_readdata <= {24'h000000, av_rd_byte};
      end
    end
  end

endmodule

// >>> dv/crf_regfile_status_assertions.sv
module crf_regfile_status_assertions
  import crf_pkg::*;
#(
  parameter int NIRQ = 8
) (
  input wire logic                   clk,              // cpu clock
  input wire logic                   rstn,             // async reset
  input wire crf_op_t                op_i,             // operand request
  input wire logic                   opnd_valid,       // operands stand
  input wire crf_ictl_t              ictl_i,           // sei cli return_from_irq_instr call
  input wire logic [NIRQ-1:0]        irq_req,          // sources
  input wire logic [15:0]            cur_pc,           // return address
  input wire logic                   irq_take,         // taken
  input wire logic [$clog2(NIRQ)-1:0] irq_vec,         // vector
  input wire logic                   push_valid,       // push
  input wire logic [15:0]            push_pc,          // pushed address
  input wire logic [7:0]             cpu_status_flags, // status
  input wire logic                   av_read,          // bus read
  input wire logic                   av_write,         // bus write
  input wire logic                   av_waitrequest    // bus wait
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // bus answer: one cycle low, then high again
  sequence s_bus_answer;
    !av_waitrequest ##1 av_waitrequest;
  endsequence
  // interrupt entry: enable dropped, return address pushed
  sequence s_irq_entry;
    !cpu_status_flags[CRF_SB_I] && push_valid && push_pc == $past(cur_pc);
  endsequence
  // properties
  chk_bus_one_wait: assert property ((av_read || av_write) && av_waitrequest |=> s_bus_answer)
    else $error("bus answer not after one wait state");
  chk_opnd_one_cycle: assert property (op_i.valid |=> opnd_valid)
    else $error("operands late");
  chk_sign_xor: assert property (cpu_status_flags[CRF_SB_S] ==
    (cpu_status_flags[CRF_SB_N] ^ cpu_status_flags[CRF_SB_V])) else $error("sign bit wrong");
  chk_gie_gate: assert property (irq_take |-> $past(cpu_status_flags[CRF_SB_I]) && $past(|irq_req))
    else $error("interrupt taken while disabled");
  chk_irq_entry: assert property (irq_take |-> s_irq_entry)
    else $error("interrupt entry wrong");
  chk_irq_prio: assert property (irq_take |->
    ((NIRQ'(1) << irq_vec) == ($past(irq_req) & (~$past(irq_req) + NIRQ'(1)))))
    else $error("wrong vector taken");
  chk_sei_sets: assert property ((ictl_i.sei || ictl_i.return_from_irq_instr) && !ictl_i.cli
    && !cpu_status_flags[CRF_SB_I] |=> cpu_status_flags[CRF_SB_I]) else $error("enable not set");
  chk_cli_blocks: assert property (ictl_i.cli |=>
    !cpu_status_flags[CRF_SB_I] && !irq_take ##1 !irq_take) else $error("interrupt after clear");
  chk_call_push: assert property (ictl_i.call |=> push_valid && push_pc == $past(cur_pc))
    else $error("call push wrong");
  chk_reset_zero: assert property ($rose(rstn) |-> cpu_status_flags == CRF_STATUS_RST)
    else $error("status not zero after reset");
endmodule

bind crf_regfile_status crf_regfile_status_assertions #(.NIRQ(NIRQ)) u_chk (
  .clk(clk), .rstn(rstn), .op_i(op_i), .opnd_valid(opnd_valid), .ictl_i(ictl_i),
  .irq_req(irq_req), .cur_pc(cur_pc), .irq_take(irq_take), .irq_vec(irq_vec),
  .push_valid(push_valid), .push_pc(push_pc), .cpu_status_flags(cpu_status_flags),
  .av_read(av_read), .av_write(av_write), .av_waitrequest(av_waitrequest));

// >>> dv/crf_alu_model.sv
module crf_alu_model
  import crf_pkg::*;
(
  input  wire logic        clk,        // cpu clock
  input  wire logic        en,         // answer operands
  input  wire logic        late,       // answer one cycle late
  input  wire logic [4:0]  dst,        // result register
  input  wire logic [15:0] opnd_a,     // operand a
  input  wire logic [15:0] opnd_b,     // operand b
  input  wire logic        opnd_valid, // operands stand
  output crf_res_t         res_o,      // result write
  output crf_flag_t        flag_o      // flag update
);
  logic [8:0] sum;
  logic [4:0] lo;
  logic       ovf;
  crf_res_t   res_c, res_q;
  crf_flag_t  flag_c, flag_q;
  // byte add and its flags, answered in the operand cycle
  assign sum = {1'b0, opnd_a[7:0]} + {1'b0, opnd_b[7:0]};
  assign lo = {1'b0, opnd_a[3:0]} + {1'b0, opnd_b[3:0]};
  assign ovf = (opnd_a[7] == opnd_b[7]) && (sum[7] != opnd_a[7]);
  assign res_c = '{en && opnd_valid, CRF_S88_8, dst, {8'h00, sum[7:0]}};
  assign flag_c = '{en && opnd_valid, CRF_FLAG_MASK,
    {2'b00, lo[4], 1'b0, ovf, sum[7], sum[7:0] == 8'h00, sum[8]}};
  // slow answer one cycle later
  always_ff @(posedge clk) begin
    res_q <= res_c;
    flag_q <= flag_c;
  end
  assign res_o = late ? res_q : res_c;
  assign flag_o = late ? flag_q : flag_c;
endmodule

// >>> dv/test_crf_regfile_status.sv
module test_crf_regfile_status
  import crf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rstn, alu_en, alu_late, av_read, av_write, fetch_valid, fetch_long;
  logic        opnd_valid, ptr_valid, ds_rvalid, exec_valid, irq_take, push_valid;
  logic        av_waitrequest, exec_long;
  logic [15:0] exec_ext;
  logic [15:0] opnd_a, opnd_b, ptr_addr, lpm_addr, fetch_word, exec_word, cur_pc, push_pc;
  logic [7:0]  ds_rdata, cpu_status_flags, irq_req, q;
  logic [6:0]  av_address;
  logic [31:0] av_writedata, av_readdata;
  logic [3:0]  av_byteenable;
  logic [2:0]  irq_vec;
  logic [4:0]  alu_dst;
  crf_op_t     op_i;
  crf_res_t    res_i;
  crf_flag_t   flag_i;
  crf_bit_t    bst_i, bld_i;
  crf_ptr_t    ptr_i;
  crf_ds_t     ds_i;
  crf_mem_t    mem_o;
  crf_ictl_t   ictl_i;
  int          failures, n_compared;
  // a, b, sum, status after the add
  logic [31:0] tv[3] = '{32'h7f01802c, 32'hff010023, 32'h01808114};
  crf_pmode_t  pm[5] = '{CRF_PM_DISP, CRF_PM_POSTINC, CRF_PM_NONE, CRF_PM_PREDEC, CRF_PM_NONE};
  logic [15:0] off[5] = '{16'h0005, 16'h0000, 16'h0001, 16'h0000, 16'h0000};

  crf_regfile_status dut (.clk, .rstn, .op_i, .opnd_a, .opnd_b, .opnd_valid, .res_i, .flag_i,
    .bst_i, .bld_i, .ptr_i, .ptr_addr, .ptr_valid, .lpm_addr, .ds_i, .ds_rdata, .ds_rvalid,
    .mem_o, .fetch_word, .fetch_valid, .fetch_long, .exec_word, .exec_ext, .exec_valid,
    .exec_long, .ictl_i, .irq_req, .cur_pc, .irq_take, .irq_vec, .push_valid, .push_pc,
    .cpu_status_flags, .av_address, .av_read, .av_write, .av_writedata, .av_byteenable,
    .av_readdata, .av_waitrequest);
  crf_alu_model alu (.clk, .en(alu_en), .late(alu_late), .dst(alu_dst), .opnd_a, .opnd_b,
    .opnd_valid, .res_o(res_i), .flag_o(flag_i));

  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    n_compared++;
    if (s !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  task end_sim;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // one bus transfer, held until waitrequest is seen low
  task bus(input logic w, input logic [6:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    av_read <= !w;
    av_write <= w;
    av_address <= a;
    av_writedata <= {24'h000000, d};
    do begin
      @(posedge clk);
      n++;
    end while (av_waitrequest !== 1'b0 && n < 20);
    if (av_waitrequest !== 1'b0) begin
      failures++;
      end_sim;
    end
    q = av_readdata[7:0];
    av_read <= 1'b0;
    av_write <= 1'b0;
  endtask

  task rd(input logic [6:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk("bus read", {8'h00, e}, {8'h00, q});
  endtask

  task dsx(input logic we, input logic io, input logic [15:0] a);
    @(posedge clk);
    ds_i <= '{1'b1, we, io, a, 8'ha5};
    @(posedge clk);
    ds_i <= '0;
    @(negedge clk);
  endtask

  // main sequence
  initial begin
    {rstn, alu_en, alu_late, av_read, av_write, fetch_valid, fetch_long} = '0;
    {op_i, bst_i, bld_i, ptr_i, ds_i, ictl_i} = '0;
    {fetch_word, cur_pc, irq_req, av_address, av_writedata, alu_dst} = '0;
    av_byteenable = 4'h1;
    failures = 0;
    n_compared = 0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rd(7'h5f, 8'h00);
    for (int i = 0; i < 32; i++) bus(1'b1, 7'(i), 8'(i) + 8'h40);
    bus(1'b1, 7'h40, 8'hff);
    rd(7'h40, 8'h00);
    rd(7'h1f, 8'h5f);
    rd(7'h00, 8'h40);
    // a write with its byte lane off leaves the register alone
    av_byteenable <= 4'h0;
    bus(1'b1, 7'h00, 8'hee);
    av_byteenable <= 4'h1;
    rd(7'h00, 8'h40);
    // adds through the alu partner, prompt and slow
    for (int k = 0; k < 3; k++) begin
      bus(1'b1, 7'h01, tv[k][31:24]);
      bus(1'b1, 7'h02, tv[k][23:16]);
      @(posedge clk);
      op_i <= '{1'b1, CRF_S88_8, 5'd1, 5'd2};
      alu_en <= 1'b1;
      alu_late <= k[0];
      alu_dst <= 5'd3;
      @(posedge clk);
      op_i <= '0;
      repeat (3) @(posedge clk);
      alu_en <= 1'b0;
      rd(7'h03, tv[k][15:8]);
      rd(7'h5f, tv[k][7:0]);
    end
    @(posedge clk);
    op_i <= '{1'b1, CRF_S16_16, 5'h1e, 5'd0};
    @(posedge clk);
    op_i <= '0;
    @(negedge clk);
    chk("pair operand", 16'h5f5e, opnd_a);
    chk("no operand b", 16'h0000, opnd_b);
    chk("table pointer", 16'h5f5e, lpm_addr);
    // pointer modes on every pair, and the unused select
    for (int s = 0; s < 4; s++) for (int j = 0; j < 5; j++) begin
      @(posedge clk);
      ptr_i <= '{1'b1, 2'(s), pm[j], 6'h05};
      @(posedge clk);
      ptr_i <= '0;
      @(negedge clk);
      chk("pointer valid", {15'h0000, s != 3}, {15'h0000, ptr_valid});
      if (s != 3) chk("pointer address", 16'h5b5a + 16'(s) * 16'h0202 + off[j], ptr_addr);
    end
    @(posedge clk);
    bst_i <= '{1'b1, 5'h1e, 3'd1};
    @(posedge clk);
    bst_i <= '0;
    bld_i <= '{1'b1, 5'h00, 3'd0};
    @(posedge clk);
    bld_i <= '0;
    rd(7'h00, 8'h41);
    rd(7'h5f, 8'h54);
    dsx(1'b0, 1'b0, 16'h001e);
    chk("data read", 16'h005e, {8'h00, ds_rdata});
    chk("read done", 16'h0001, {15'h0000, ds_rvalid});
    dsx(1'b0, 1'b1, 16'h003f);
    chk("io status", 16'h0054, {8'h00, ds_rdata});
    dsx(1'b1, 1'b1, 16'h0005);
    chk("io forward", 16'h0025, mem_o.addr);
    chk("forward valid", 16'h0001, {15'h0000, mem_o.valid});
    dsx(1'b1, 1'b0, 16'h0100);
    chk("extended", 16'h0100, mem_o.addr);
    @(posedge clk);
    fetch_word <= 16'h1234;
    fetch_valid <= 1'b1;
    @(posedge clk);
    fetch_word <= 16'h9400;
    fetch_long <= 1'b1;
    @(negedge clk);
    chk("executed word", 16'h1234, exec_word);
    chk("word ready", 16'h0001, {15'h0000, exec_valid});
    // two-word instruction: first half held back, ready with the second
    @(posedge clk);
    fetch_word <= 16'h5678;
    fetch_long <= 1'b0;
    @(negedge clk);
    chk("first half", 16'h0002, {14'h0000, exec_long, exec_valid});
    @(posedge clk);
    fetch_valid <= 1'b0;
    @(negedge clk);
    chk("second word", 16'h5678, exec_ext);
    chk("long word", 16'h9400, exec_word);
    chk("long ready", 16'h0003, {14'h0000, exec_long, exec_valid});
    // interrupts: gated, taken, returned, blocked, call push
    @(posedge clk);
    cur_pc <= 16'h0abc;
    irq_req <= 8'h0c;
    repeat (3) @(negedge clk);
    chk("gated", 16'h0000, {15'h0000, irq_take});
    @(posedge clk);
    ictl_i <= '{1'b1, 1'b0, 1'b0, 1'b0};
    @(posedge clk);
    ictl_i <= '0;
    for (int n = 0; n < 5 && irq_take !== 1'b1; n++) @(negedge clk);
    if (irq_take !== 1'b1) begin
      failures++;
      end_sim;
    end
    chk("vector", 16'h0002, {13'h0000, irq_vec});
    chk("return address", 16'h0abc, push_pc);
    chk("enable cleared", 16'h0000, {8'h00, cpu_status_flags & 8'h80});
    // handler software saves the status and puts it back itself
    rd(7'h5f, 8'h54);
    bus(1'b1, 7'h5f, q);
    @(posedge clk);
    irq_req <= 8'h00;
    ictl_i <= '{1'b0, 1'b0, 1'b1, 1'b0};
    @(posedge clk);
    ictl_i <= '0;
    @(negedge clk);
    chk("enable set", 16'h0080, {8'h00, cpu_status_flags & 8'h80});
    @(posedge clk);
    irq_req <= 8'h80;
    ictl_i <= '{1'b0, 1'b1, 1'b0, 1'b0};
    @(posedge clk);
    ictl_i <= '0;
    repeat (2) @(negedge clk);
    chk("clear blocks", 16'h0000, {7'h00, irq_take, cpu_status_flags & 8'h80});
    @(posedge clk);
    irq_req <= 8'h00;
    ictl_i <= '{1'b0, 1'b0, 1'b0, 1'b1};
    @(posedge clk);
    ictl_i <= '0;
    @(negedge clk);
    chk("call push", 16'h0001, {15'h0000, push_valid});
    // second reset in mid-run clears status and registers again
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rd(7'h5f, 8'h00);
    rd(7'h1e, 8'h00);
    end_sim;
  end
endmodule
